// ---- src/pdsd_dev.sv ----
`timescale 1ns/1ps
module pdsd_dev
    import pdsd_pkg::*;
#(
    parameter logic P_AVAILABLE = 1'b1,
    parameter logic P_POLARITY = 1'b0,
    parameter logic P_ADDRESSED = 1'b0,
    parameter logic P_ADDR_BYTE1 = 1'b0,
    parameter logic [2:0] P_BIT_POS = 3'h0,
    parameter logic [7:0] P_LOCAL_ADDR = 8'h00,
    parameter logic [3:0] P_MODE_FLAGS = 4'h0,
    parameter logic [3:0] P_DUMMY = 4'h0,
    parameter logic [7:0] P_RD_OP = 8'h05,
    parameter logic [7:0] P_WR_OP = 8'h01
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Link to the host.
    pdsd_if.dev link,
    // Device user side.
    input wire logic i_deep_power_down,
    output logic [7:0] o_status_reg,
    output logic o_write_pulse
);
    logic [31:0] word;
    logic [7:0] other_bits;
    logic [7:0] next_other_bits;
    logic [7:0] reg_view;
    logic [7:0] addr_byte;
    logic addr_ok;
    logic dummy_ok;
    logic flagged;
    logic is_rd;
    logic is_wr;
    logic next_word_valid;
    logic next_rsp_valid;
    logic next_rsp_err;
    logic [7:0] next_rsp_data;
    logic next_write_pulse;

    // The held parameter word; bit 29 is always returned as zero.
    assign word = {P_AVAILABLE, P_POLARITY, 1'b0, P_ADDRESSED, P_ADDR_BYTE1, P_BIT_POS,
        (P_ADDRESSED ? P_LOCAL_ADDR : {P_MODE_FLAGS, P_DUMMY}), P_RD_OP, P_WR_OP};

    always_comb begin
        reg_view = other_bits;
        // With positive polarity a zero status bit means powered down.
        reg_view[P_BIT_POS] = P_POLARITY ? i_deep_power_down : ~i_deep_power_down;
        addr_byte = P_ADDR_BYTE1 ? link.cmd_addr[15:8] : link.cmd_addr[7:0];
        addr_ok = P_ADDRESSED ? (link.cmd_addr_used && addr_byte == P_LOCAL_ADDR &&
            !(P_ADDR_BYTE1 && link.cmd_addr_width == PDSD_AW_8)) : !link.cmd_addr_used;
        unique case (link.cmd_mode)
            PDSD_MODE_4S4S4S: flagged = P_MODE_FLAGS[0];
            PDSD_MODE_4S4D4D: flagged = P_MODE_FLAGS[1];
            PDSD_MODE_8S8S8S: flagged = P_MODE_FLAGS[2];
            PDSD_MODE_8D8D8D: flagged = P_MODE_FLAGS[3];
            default: flagged = 1'b0;
        endcase
        if (link.cmd_mode == PDSD_MODE_111) begin
            dummy_ok = (link.cmd_dummy == 4'h0);
        end else if (!P_ADDRESSED && flagged) begin
            dummy_ok = (link.cmd_dummy == P_DUMMY);
        end else begin
            dummy_ok = 1'b1;
        end
        is_rd = P_AVAILABLE && P_RD_OP != PDSD_NO_OPCODE && link.cmd_opcode == P_RD_OP;
        is_wr = P_AVAILABLE && P_WR_OP != PDSD_NO_OPCODE && link.cmd_opcode == P_WR_OP;
        next_word_valid = link.word_req;
        next_rsp_valid = 1'b0;
        next_rsp_err = 1'b0;
        next_rsp_data = 8'h00;
        next_other_bits = other_bits;
        next_write_pulse = 1'b0;
        if (link.cmd_valid) begin
            if ((is_rd || is_wr) && addr_ok && dummy_ok) begin
                next_rsp_valid = 1'b1;
                if (is_rd) begin
                    next_rsp_data = reg_view;
                end else begin
                    next_other_bits = link.cmd_wdata;
                    next_write_pulse = 1'b1;
                end
            end else begin
                next_rsp_err = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            other_bits <= 8'h00;
            link.word_valid <= 1'b0;
            link.word_data <= 32'h0000_0000;
            link.rsp_valid <= 1'b0;
            link.rsp_err <= 1'b0;
            link.rsp_data <= 8'h00;
            o_status_reg <= 8'h00;
            o_write_pulse <= 1'b0;
        end else begin
            other_bits <= next_other_bits;
            link.word_valid <= next_word_valid;
            link.word_data <= next_word_valid ? word : 32'h0000_0000;
            link.rsp_valid <= next_rsp_valid;
            link.rsp_err <= next_rsp_err;
            link.rsp_data <= next_rsp_data;
            o_status_reg <= reg_view;
            o_write_pulse <= next_write_pulse;
        end
    end
endmodule // pdsd_dev

// ---- src/pdsd_host.sv ----
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module pdsd_host
    import pdsd_pkg::*;
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Software register port.
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Link to the device.
    pdsd_if.host link,
    // Decoded result.
    output logic o_busy,
    output logic o_deep_power_down
);
    pdsd_state_e state;
    pdsd_state_e next_state;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] word;
    logic [31:0] next_word;
    logic loaded;
    logic next_loaded;
    logic done;
    logic next_done;
    logic err;
    logic next_err;
    logic down;
    logic next_down;
    logic [7:0] raw;
    logic [7:0] next_raw;
    logic [31:0] next_rdata;
    logic next_word_req;
    logic next_cmd_valid;
    logic [7:0] next_opcode;
    logic next_addr_used;
    logic [31:0] next_addr;
    logic [3:0] next_dummy;
    logic [7:0] next_cmd_wdata;
    logic [2:0] mode;
    logic [1:0] aw;
    logic [7:0] rd_op;
    logic [7:0] wr_op;
    logic [7:0] op;
    logic [2:0] pos;
    logic flagged;
    logic ctrl_wr;
    logic start;

    assign ctrl_wr = i_wr && i_addr == PDSD_OFS_CTRL;
    // Commands start only on a control write, so their mode and width come from the write data.
    assign mode = i_wdata[PDSD_CTRL_MODE_MSB:PDSD_CTRL_MODE_LSB];
    assign aw = i_wdata[PDSD_CTRL_AW_MSB:PDSD_CTRL_AW_LSB];
    assign rd_op = word[PDSD_RDOP_MSB:PDSD_RDOP_LSB];
    assign wr_op = word[PDSD_WROP_MSB:PDSD_WROP_LSB];
    assign pos = word[PDSD_POS_MSB:PDSD_POS_LSB];

    always_comb begin
        next_ctrl = ctrl;
        next_state = state;
        next_word = word;
        next_loaded = loaded;
        next_done = done;
        next_err = err;
        next_down = down;
        next_raw = raw;
        next_word_req = 1'b0;
        next_cmd_valid = 1'b0;
        next_opcode = link.cmd_opcode;
        next_addr_used = link.cmd_addr_used;
        next_addr = link.cmd_addr;
        next_dummy = link.cmd_dummy;
        next_cmd_wdata = link.cmd_wdata;
        op = 8'h00;
        start = 1'b0;
        unique case (mode)
            PDSD_MODE_4S4S4S: flagged = word[PDSD_FLAG_4S];
            PDSD_MODE_4S4D4D: flagged = word[PDSD_FLAG_4D];
            PDSD_MODE_8S8S8S: flagged = word[PDSD_FLAG_8S];
            PDSD_MODE_8D8D8D: flagged = word[PDSD_FLAG_8D];
            default: flagged = 1'b0;
        endcase
        if (ctrl_wr) begin
            next_ctrl = i_wdata & ~32'h0000_0007;
        end
        unique case (state)
            PDSD_S_IDLE: begin
                if (ctrl_wr && i_wdata[PDSD_CTRL_FETCH]) begin
                    next_word_req = 1'b1;
                    next_loaded = 1'b0;
                    next_done = 1'b0;
                    next_err = 1'b0;
                    next_state = PDSD_S_WAIT_WORD;
                end else if (ctrl_wr && (i_wdata[PDSD_CTRL_CHECK] || i_wdata[PDSD_CTRL_WRITE])) begin
                    op = i_wdata[PDSD_CTRL_CHECK] ? rd_op : wr_op;
                    next_done = 1'b0;
                    next_err = 1'b1;
                    // The word must be loaded and report the bit before any command goes out.
                    if (loaded && word[PDSD_AVAIL_BIT] && op != PDSD_NO_OPCODE) begin
                        start = 1'b1;
                    end
                    // A byte-1 local address cannot be carried by an 8-bit address.
                    if (word[PDSD_ADDRESSED_BIT] && word[PDSD_BYTE1_BIT] &&
                        aw == PDSD_AW_8) begin
                        start = 1'b0;
                    end
                    if (start) begin
                        next_err = 1'b0;
                        next_cmd_valid = 1'b1;
                        next_opcode = op;
                        next_cmd_wdata = i_wdata[PDSD_CTRL_WD_MSB:PDSD_CTRL_WD_LSB];
                        next_addr_used = word[PDSD_ADDRESSED_BIT];
                        next_addr = 32'h0000_0000;
                        if (word[PDSD_ADDRESSED_BIT]) begin
                            if (word[PDSD_BYTE1_BIT]) begin
                                next_addr[15:8] = word[PDSD_LADDR_MSB:PDSD_LADDR_LSB];
                            end else begin
                                next_addr[7:0] = word[PDSD_LADDR_MSB:PDSD_LADDR_LSB];
                            end
                        end
                        if (i_wdata[PDSD_CTRL_MODE_MSB:PDSD_CTRL_MODE_LSB] == PDSD_MODE_111) begin
                            next_dummy = 4'h0;
                        end else if (!word[PDSD_ADDRESSED_BIT] && flagged) begin
                            next_dummy = word[PDSD_DUMMY_MSB:PDSD_DUMMY_LSB];
                        end else begin
                            // Unflagged modes are still tried, with the software dummy count.
                            next_dummy = i_wdata[PDSD_CTRL_DUM_MSB:PDSD_CTRL_DUM_LSB];
                        end
                        next_state = PDSD_S_WAIT_RSP;
                    end
                end
            end
            PDSD_S_WAIT_WORD: begin
                if (link.word_valid) begin
                    next_word = link.word_data;
                    next_loaded = 1'b1;
                    next_done = 1'b1;
                    next_state = PDSD_S_IDLE;
                end
            end
            PDSD_S_WAIT_RSP: begin
                if (link.rsp_valid || link.rsp_err) begin
                    next_done = 1'b1;
                    next_err = link.rsp_err;
                    if (link.rsp_valid && link.cmd_opcode == rd_op) begin
                        next_raw = link.rsp_data;
                        // Powered down when the bit equals the polarity flag.
                        next_down = (link.rsp_data[pos] == word[PDSD_POL_BIT]);
                    end
                    next_state = PDSD_S_IDLE;
                end
            end
            default: next_state = PDSD_S_IDLE;
        endcase
        next_rdata = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr)
                PDSD_OFS_CTRL: next_rdata = ctrl;
                PDSD_OFS_STATUS: next_rdata = {27'h0, down, err, done, loaded,
                    state != PDSD_S_IDLE};
                PDSD_OFS_WORD: next_rdata = word;
                PDSD_OFS_RESULT: next_rdata = {24'h0, raw};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        if (next_ctrl[PDSD_CTRL_AW_MSB:PDSD_CTRL_AW_LSB] == 2'h3) begin
            next_ctrl[PDSD_CTRL_AW_MSB:PDSD_CTRL_AW_LSB] = PDSD_AW_32;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state <= PDSD_S_IDLE;
            ctrl <= PDSD_CTRL_RESET;
            word <= 32'h0000_0000;
            loaded <= 1'b0;
            done <= 1'b0;
            err <= 1'b0;
            down <= 1'b0;
            raw <= 8'h00;
            o_rdata <= 32'h0000_0000;
            o_busy <= 1'b0;
            o_deep_power_down <= 1'b0;
            link.word_req <= 1'b0;
            link.cmd_valid <= 1'b0;
            link.cmd_opcode <= 8'h00;
            link.cmd_addr_used <= 1'b0;
            link.cmd_addr_width <= PDSD_AW_8;
            link.cmd_addr <= 32'h0000_0000;
            link.cmd_mode <= PDSD_MODE_111;
            link.cmd_dummy <= 4'h0;
            link.cmd_wdata <= 8'h00;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            word <= next_word;
            loaded <= next_loaded;
            done <= next_done;
            err <= next_err;
            down <= next_down;
            raw <= next_raw;
            o_rdata <= next_rdata;
            o_busy <= next_state != PDSD_S_IDLE;
            o_deep_power_down <= next_down;
            link.word_req <= next_word_req;
            link.cmd_valid <= next_cmd_valid;
            link.cmd_opcode <= next_opcode;
            link.cmd_addr_used <= next_addr_used;
            link.cmd_addr_width <= next_ctrl[PDSD_CTRL_AW_MSB:PDSD_CTRL_AW_LSB];
            link.cmd_addr <= next_addr;
            link.cmd_mode <= next_ctrl[PDSD_CTRL_MODE_MSB:PDSD_CTRL_MODE_LSB];
            link.cmd_dummy <= next_dummy;
            link.cmd_wdata <= next_cmd_wdata;
        end
    end
endmodule // pdsd_host

// ---- src/pdsd_if.sv ----
`timescale 1ns/1ps
interface pdsd_if;
    // Parameter word fetch.
    logic word_req;
    logic word_valid;
    logic [31:0] word_data;
    // Status register command.
    logic cmd_valid;
    logic [7:0] cmd_opcode;
    logic cmd_addr_used;
    logic [1:0] cmd_addr_width;
    logic [31:0] cmd_addr;
    logic [2:0] cmd_mode;
    logic [3:0] cmd_dummy;
    logic [7:0] cmd_wdata;
    // Command answer.
    logic rsp_valid;
    logic rsp_err;
    logic [7:0] rsp_data;

    modport dev (
        input word_req, cmd_valid, cmd_opcode, cmd_addr_used, cmd_addr_width, cmd_addr,
        input cmd_mode, cmd_dummy, cmd_wdata,
        output word_valid, word_data, rsp_valid, rsp_err, rsp_data
    );
    modport host (
        output word_req, cmd_valid, cmd_opcode, cmd_addr_used, cmd_addr_width, cmd_addr,
        output cmd_mode, cmd_dummy, cmd_wdata,
        input word_valid, word_data, rsp_valid, rsp_err, rsp_data
    );
endinterface // pdsd_if

// ---- src/pdsd_pkg.sv ----
package pdsd_pkg;
    // Bit positions of the power-down status parameter word.
    localparam int unsigned PDSD_AVAIL_BIT = 31;
    localparam int unsigned PDSD_POL_BIT = 30;
    localparam int unsigned PDSD_RSVD_BIT = 29;
    localparam int unsigned PDSD_ADDRESSED_BIT = 28;
    localparam int unsigned PDSD_BYTE1_BIT = 27;
    localparam int unsigned PDSD_POS_MSB = 26;
    localparam int unsigned PDSD_POS_LSB = 24;
    localparam int unsigned PDSD_LADDR_MSB = 23;
    localparam int unsigned PDSD_LADDR_LSB = 16;
    localparam int unsigned PDSD_FLAG_8D = 23;
    localparam int unsigned PDSD_FLAG_8S = 22;
    localparam int unsigned PDSD_FLAG_4D = 21;
    localparam int unsigned PDSD_FLAG_4S = 20;
    localparam int unsigned PDSD_DUMMY_MSB = 19;
    localparam int unsigned PDSD_DUMMY_LSB = 16;
    localparam int unsigned PDSD_RDOP_MSB = 15;
    localparam int unsigned PDSD_RDOP_LSB = 8;
    localparam int unsigned PDSD_WROP_MSB = 7;
    localparam int unsigned PDSD_WROP_LSB = 0;
    localparam logic [7:0] PDSD_NO_OPCODE = 8'h00;

    // Host register offsets and reset values.
    localparam logic [7:0] PDSD_OFS_CTRL = 8'h00;
    localparam logic [7:0] PDSD_OFS_STATUS = 8'h04;
    localparam logic [7:0] PDSD_OFS_WORD = 8'h08;
    localparam logic [7:0] PDSD_OFS_RESULT = 8'h0c;
    localparam logic [31:0] PDSD_CTRL_RESET = 32'h0000_0000;

    // Control register fields.
    localparam int unsigned PDSD_CTRL_FETCH = 0;
    localparam int unsigned PDSD_CTRL_CHECK = 1;
    localparam int unsigned PDSD_CTRL_WRITE = 2;
    localparam int unsigned PDSD_CTRL_AW_MSB = 5;
    localparam int unsigned PDSD_CTRL_AW_LSB = 4;
    localparam int unsigned PDSD_CTRL_MODE_MSB = 10;
    localparam int unsigned PDSD_CTRL_MODE_LSB = 8;
    localparam int unsigned PDSD_CTRL_DUM_MSB = 15;
    localparam int unsigned PDSD_CTRL_DUM_LSB = 12;
    localparam int unsigned PDSD_CTRL_WD_MSB = 23;
    localparam int unsigned PDSD_CTRL_WD_LSB = 16;

    // Address widths the host may send.
    localparam logic [1:0] PDSD_AW_8 = 2'h0;
    localparam logic [1:0] PDSD_AW_24 = 2'h1;
    localparam logic [1:0] PDSD_AW_32 = 2'h2;

    typedef enum logic [2:0] {
        PDSD_MODE_111 = 3'b000,
        PDSD_MODE_4S4S4S = 3'b001,
        PDSD_MODE_4S4D4D = 3'b010,
        PDSD_MODE_8S8S8S = 3'b011,
        PDSD_MODE_8D8D8D = 3'b100
    } pdsd_mode_e;

    typedef enum logic [2:0] {
        PDSD_S_IDLE = 3'b000,
        PDSD_S_WAIT_WORD = 3'b001,
        PDSD_S_WAIT_RSP = 3'b010
    } pdsd_state_e;
endpackage

// ---- testbench/pdsd_sva.sv ----
`timescale 1ns/1ps
module pdsd_sva
    import pdsd_pkg::*;
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Link signals.
    input wire logic word_req,
    input wire logic word_valid,
    input wire logic [31:0] word_data,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic cmd_addr_used,
    input wire logic [1:0] cmd_addr_width,
    input wire logic [31:0] cmd_addr,
    input wire logic [2:0] cmd_mode,
    input wire logic [3:0] cmd_dummy,
    input wire logic [7:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [7:0] rsp_data
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    // Last parameter word seen on the link, so host commands can be judged against it.
    logic [31:0] word_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            word_q <= 32'h0000_0000;
        end else if (word_valid) begin
            word_q <= word_data;
        end
    end

    a_word_answer_next: assert property (word_req |=> word_valid ##1 !word_valid)
        else $error("word answer not one cycle after request");
    a_rsvd_bit_zero: assert property (word_valid |-> !word_data[PDSD_RSVD_BIT])
        else $error("reserved word bit not zero");
    a_cmd_needs_avail: assert property (cmd_valid |-> word_q[PDSD_AVAIL_BIT])
        else $error("command issued without available status bit");
    a_direct_no_addr: assert property (cmd_valid && !word_q[28] |-> !cmd_addr_used)
        else $error("direct command carries an address");
    a_local_addr_place: assert property (cmd_valid && word_q[28] |-> cmd_addr_used &&
        ((word_q[27] ? cmd_addr[15:8] : cmd_addr[7:0]) == word_q[23:16]))
        else $error("local address not in the indicated byte");
    a_byte1_not_8bit: assert property (cmd_valid && word_q[28] && word_q[27] |->
        cmd_addr_width != PDSD_AW_8)
        else $error("byte one placement used with 8-bit address");
    a_single_lane_dummy: assert property (cmd_valid && cmd_mode == PDSD_MODE_111 |->
        cmd_dummy == 4'h0)
        else $error("single-lane command with dummy cycles");
    a_opcode_present: assert property (cmd_valid |-> cmd_opcode != PDSD_NO_OPCODE &&
        (cmd_opcode == word_q[15:8] || cmd_opcode == word_q[7:0]))
        else $error("command opcode not taken from the word");
    a_rsp_one_cycle: assert property (cmd_valid |=> (rsp_valid ^ rsp_err) ##1
        !(rsp_valid || rsp_err))
        else $error("command answer not exactly one cycle after request");

    c_word_fetch: cover property (word_valid);
    c_rsp_ok: cover property (rsp_valid);
    c_rsp_refused: cover property (rsp_err);
endmodule // pdsd_sva

// ---- testbench/power_down_status_descriptor_tb_top.sv ----
`timescale 1ns/1ps
module power_down_status_descriptor_tb_top
    import pdsd_pkg::*;
;
    logic i_core_clk;
    logic i_reset_n;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic o_busy;
    logic o_deep_power_down;
    logic i_deep_power_down;
    logic [7:0] o_status_reg;
    logic o_write_pulse;
    int mismatches;
    int comparisons;
    int pulses;
    logic [31:0] rv;

    pdsd_if link_bus();

    // Addressed access, byte-1 placement, inverted polarity, status at bit 3.
    pdsd_dev #(.P_POLARITY(1'b1), .P_ADDRESSED(1'b1), .P_ADDR_BYTE1(1'b1),
        .P_BIT_POS(3'h3), .P_LOCAL_ADDR(8'h5a)) pdsd_dev_i (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link_bus),
        .i_deep_power_down(i_deep_power_down), .o_status_reg(o_status_reg),
        .o_write_pulse(o_write_pulse));

    pdsd_host pdsd_host_i (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link_bus), .o_busy(o_busy),
        .o_deep_power_down(o_deep_power_down));

    pdsd_sva pdsd_sva_i (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .word_req(link_bus.word_req),
        .word_valid(link_bus.word_valid), .word_data(link_bus.word_data),
        .cmd_valid(link_bus.cmd_valid), .cmd_opcode(link_bus.cmd_opcode),
        .cmd_addr_used(link_bus.cmd_addr_used), .cmd_addr_width(link_bus.cmd_addr_width),
        .cmd_addr(link_bus.cmd_addr), .cmd_mode(link_bus.cmd_mode),
        .cmd_dummy(link_bus.cmd_dummy), .cmd_wdata(link_bus.cmd_wdata),
        .rsp_valid(link_bus.rsp_valid), .rsp_err(link_bus.rsp_err),
        .rsp_data(link_bus.rsp_data));

    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        if (o_write_pulse === 1'b1) begin
            pulses++;
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge i_core_clk);
        i_addr <= addr;
        i_wdata <= data;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe cycle.
    task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
        @(posedge i_core_clk);
        i_addr <= addr;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        data = o_rdata;
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        for (int n = 0; n < 40; n++) begin
            reg_rd(PDSD_OFS_STATUS, s);
            if (s[0] === 1'b0) begin
                return;
            end
        end
        mismatches++;
        $display("[ERR] busy wait expected 0 seen 1");
        final_report();
    endtask

    // Starts a status check and compares done, error, decoded flag and the raw status byte bits selected by raw_mask.
    task automatic run_check(input logic [31:0] ctrl, input logic down, input logic [7:0] raw,
        input logic [7:0] raw_mask);
        reg_wr(PDSD_OFS_CTRL, ctrl);
        wait_idle();
        reg_rd(PDSD_OFS_STATUS, rv);
        chk32("status", {27'h0, down, 4'h4}, rv & 32'h0000_001c);
        chk32("down_out", {31'h0, down}, {31'h0, o_deep_power_down});
        chk32("busy_done", 32'h0000_0000, {31'h0, o_busy});
        // With inverted polarity the device status bit equals the decoded flag.
        chk32("dev_status_bit", {31'h0, down}, {31'h0, o_status_reg[3]});
        reg_rd(PDSD_OFS_RESULT, rv);
        chk32("raw", {24'h0, raw & raw_mask}, rv & {24'h0, raw_mask});
    endtask

    initial begin
        i_reset_n = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_deep_power_down = 1'b0;
        mismatches = 0;
        comparisons = 0;
        pulses = 0;
        repeat (5) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        reg_rd(PDSD_OFS_CTRL, rv);
        chk32("ctrl_reset", PDSD_CTRL_RESET, rv);
        reg_rd(8'h10, rv);
        chk32("unmapped", 32'h0000_0000, rv);
        reg_wr(PDSD_OFS_CTRL, 32'h0000_0030);
        reg_rd(PDSD_OFS_CTRL, rv);
        chk32("aw3_stored_as_32", 32'h0000_0020, rv);
        reg_rd(PDSD_OFS_STATUS, rv);
        chk32("status_reset", 32'h0000_0000, rv);
        reg_wr(PDSD_OFS_CTRL, 32'h0000_0022);
        wait_idle();
        reg_rd(PDSD_OFS_STATUS, rv);
        chk32("check_unloaded", 32'h0000_0008, rv & 32'h0000_000c);
        reg_wr(PDSD_OFS_CTRL, 32'h0000_0001);
        #1;
        chk32("busy_fetch", 32'h0000_0001, {31'h0, o_busy});
        wait_idle();
        reg_rd(PDSD_OFS_WORD, rv);
        chk32("word", 32'hdb5a_0501, rv);
        // Device status bit is 1 when powered down, so the decoded flag follows the input.
        for (int aw = 1; aw <= 2; aw++) begin
            for (int v = 0; v <= 1; v++) begin
                @(posedge i_core_clk);
                i_deep_power_down <= 1'(v);
                run_check({26'h0, 2'(aw), 4'h2}, 1'(v), {4'h0, 1'(v), 3'h0}, 8'h08);
            end
        end
        reg_wr(PDSD_OFS_CTRL, 32'h0000_0002);
        wait_idle();
        reg_rd(PDSD_OFS_STATUS, rv);
        chk32("aw8_refused", 32'h0000_0008, rv & 32'h0000_000c);
        // Writing bit 3 set shows that the status bit itself is not writable.
        reg_wr(PDSD_OFS_CTRL, 32'h00ad_0024);
        wait_idle();
        chk32("write_pulses", 32'h0000_0001, 32'(pulses));
        @(posedge i_core_clk);
        i_deep_power_down <= 1'b0;
        run_check(32'h0000_0022, 1'b0, 8'ha5, 8'hff);
        run_check(32'h0000_5122, 1'b0, 8'ha5, 8'hff);
        final_report();
    end
endmodule // power_down_status_descriptor_tb_top
